// ===== pkg/difl_map.svh
// function codes, field widths and timing counts for the digital input function logic
// assumes a 125 MHz drive clock
`ifndef DIFL_MAP_SVH
`define DIFL_MAP_SVH
`define FC_PID_INT_RESET 8'h30
`define FC_PID_INT_HOLD 8'h31
`define FC_PRESET_BIT4 8'h32
`define FC_PID_SFS_CANCEL 8'h34
`define FC_PID_SIGN_INV 8'h35
`define FC_FWD_RUN 8'h40
`define FC_REV_RUN 8'h41
`define FC_RUN2 8'h42
`define FC_DIR2 8'h43
`define FC_OFFSET1 8'h44
`define FC_OFFSET2 8'h45
`define FC_OFFSET3 8'h46
`define FC_DC_BRAKE 8'h60
`define FC_SEARCH1 8'h61
`define FC_SEARCH2 8'h62
`define FC_KEB_NC 8'h65
`define FC_KEB_NO 8'h66
`define FC_LOOPBACK 8'h67
`define FC_HSB 8'h68
`define FC_ENABLE 8'h6A
`define FC_BIAS_UP 8'h75
`define FC_BIAS_DOWN 8'h76
`define CLK_MHZ 125
`define BIAS_SAVE_S 5
`define BIAS_SAVE_CYC (`BIAS_SAVE_S * `CLK_MHZ * 1000000)
`define BIAS_W 16
`endif

// ===== pkg/difl_pkg.sv
// types shared by the digital input function logic
// no assumptions beyond the map header
`default_nettype none
package difl_pkg;
	typedef enum logic [1:0] {RUN_IDLE, RUN_ACTIVE, RUN_WAIT_CYCLE} run_state_t;
	typedef struct packed {
		logic int_reset;
		logic int_hold;
		logic sfs_cancel;
		logic sign_inv;
	} pid_ctl_t;
	typedef struct packed {
		logic run;
		logic reverse;
		logic ext_fault;
		logic stop_cmd;
	} run_ctl_t;
endpackage
`default_nettype wire

// ===== hdl/digital_input_function_logic.sv
// decodes multi-function digital inputs into run, braking and pid control actions
// inputs are synchronous to clk; config codes are held static while running
`default_nettype none
`include "difl_map.svh"
module digital_input_function_logic
	import difl_pkg::*;
#(
	parameter int N_IN = 7,
	parameter int SAVE_CYCLES = `BIAS_SAVE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N_IN-1:0] term_in,
	input wire logic [N_IN*8-1:0] input_function_select,
	input wire logic [N_IN-1:0] term_invert,
	input wire logic [2:0] preset_sel_low,
	input wire logic [`BIAS_W-1:0] offset_freq1,
	input wire logic [`BIAS_W-1:0] offset_freq2,
	input wire logic [`BIAS_W-1:0] offset_freq3,
	input wire logic [`BIAS_W-1:0] bias_step,
	input wire logic bias_save_enable,
	input wire logic jog_cmd,
	input wire logic motor_stopped,
	input wire logic speed_search_at_start,
	input wire logic speed_search_method,
	input wire logic [1:0] stopping_method_select,
	input wire logic serial_rx,
	output logic serial_tx,
	output logic loopback_ok,
	output logic loopback_active,
	output pid_ctl_t pid_ctl,
	output run_ctl_t run_ctl,
	output logic [1:0] stop_method,
	output logic [3:0] preset_sel,
	output logic [`BIAS_W-1:0] offset_total,
	output logic dc_brake,
	output logic search_enable,
	output logic search_from_max,
	output logic search_from_ref,
	output logic config_conflict_error,
	output logic kinetic_energy_ride_through,
	output logic high_slip_braking,
	output logic drive_disabled_indication,
	output logic [`BIAS_W-1:0] bias_value,
	output logic [`BIAS_W-1:0] saved_bias_value,
	output logic bias_saved_pulse
);
	localparam int CW = $clog2(SAVE_CYCLES + 1);

	// true if any terminal carries the code, and the combined closed level of those terminals
	function automatic logic [1:0] fn_lookup(input logic [N_IN*8-1:0] sel,
			input logic [N_IN-1:0] lvl, input logic [7:0] code);
		logic [1:0] r;
		r = 2'b00;
		for (int i = 0; i < N_IN; i++) begin
			if (sel[i*8 +: 8] == code) begin
				r[1] = 1'b1;
				r[0] = r[0] | lvl[i];
			end
		end
		return r;
	endfunction

	logic [N_IN-1:0] lvl_reg, lvl_next;
	always_comb begin
		lvl_next = term_in ^ term_invert;
	end
	always_ff @(posedge clk) begin
		if (rst) lvl_reg <= '0;
		else lvl_reg <= lvl_next;
	end

	logic [1:0] f_ir, f_ih, f_p4, f_sfs, f_inv, f_fwd, f_rev, f_run2, f_dir2;
	logic [1:0] f_o1, f_o2, f_o3, f_dc, f_s1, f_s2, f_knc, f_kno, f_lb, f_hsb;
	logic [1:0] f_en, f_up, f_dn;
	always_comb begin
		f_ir = fn_lookup(input_function_select, lvl_reg, `FC_PID_INT_RESET);
		f_ih = fn_lookup(input_function_select, lvl_reg, `FC_PID_INT_HOLD);
		f_p4 = fn_lookup(input_function_select, lvl_reg, `FC_PRESET_BIT4);
		f_sfs = fn_lookup(input_function_select, lvl_reg, `FC_PID_SFS_CANCEL);
		f_inv = fn_lookup(input_function_select, lvl_reg, `FC_PID_SIGN_INV);
		f_fwd = fn_lookup(input_function_select, lvl_reg, `FC_FWD_RUN);
		f_rev = fn_lookup(input_function_select, lvl_reg, `FC_REV_RUN);
		f_run2 = fn_lookup(input_function_select, lvl_reg, `FC_RUN2);
		f_dir2 = fn_lookup(input_function_select, lvl_reg, `FC_DIR2);
		f_o1 = fn_lookup(input_function_select, lvl_reg, `FC_OFFSET1);
		f_o2 = fn_lookup(input_function_select, lvl_reg, `FC_OFFSET2);
		f_o3 = fn_lookup(input_function_select, lvl_reg, `FC_OFFSET3);
		f_dc = fn_lookup(input_function_select, lvl_reg, `FC_DC_BRAKE);
		f_s1 = fn_lookup(input_function_select, lvl_reg, `FC_SEARCH1);
		f_s2 = fn_lookup(input_function_select, lvl_reg, `FC_SEARCH2);
		f_knc = fn_lookup(input_function_select, lvl_reg, `FC_KEB_NC);
		f_kno = fn_lookup(input_function_select, lvl_reg, `FC_KEB_NO);
		f_lb = fn_lookup(input_function_select, lvl_reg, `FC_LOOPBACK);
		f_hsb = fn_lookup(input_function_select, lvl_reg, `FC_HSB);
		f_en = fn_lookup(input_function_select, lvl_reg, `FC_ENABLE);
		f_up = fn_lookup(input_function_select, lvl_reg, `FC_BIAS_UP);
		f_dn = fn_lookup(input_function_select, lvl_reg, `FC_BIAS_DOWN);
	end

	// run sequencing
	run_state_t st_reg, st_next;
	logic hsb_reg, hsb_next, dc_reg, dc_next;
	run_ctl_t run_reg, run_next;
	logic dis_reg, dis_next;
	logic [1:0] stm_reg, stm_next;
	logic run_cmd, rev_cmd, fault, enabled;
	always_comb begin
		if (f_fwd[1] | f_rev[1]) begin
			run_cmd = f_fwd[0] ^ f_rev[0];
			rev_cmd = f_rev[0];
		end else begin
			run_cmd = f_run2[0];
			rev_cmd = f_dir2[0];
		end
		fault = f_fwd[0] & f_rev[0];
		enabled = ~f_en[1] | f_en[0];
		st_next = st_reg;
		hsb_next = hsb_reg;
		if (f_hsb[0]) hsb_next = 1'b1;
		else if (motor_stopped) hsb_next = 1'b0;
		case (st_reg)
			RUN_IDLE: begin
				// run held while disabled must be cycled
				if (run_cmd & ~enabled) st_next = RUN_WAIT_CYCLE;
				else if (run_cmd & ~fault & ~hsb_next) st_next = RUN_ACTIVE;
			end
			RUN_ACTIVE: begin
				if (~enabled) st_next = RUN_WAIT_CYCLE;
				else if (~run_cmd | fault | hsb_next) st_next = RUN_IDLE;
			end
			RUN_WAIT_CYCLE: begin
				if (~run_cmd) st_next = RUN_IDLE;
			end
			default: st_next = RUN_IDLE;
		endcase
		run_next.run = (st_next == RUN_ACTIVE) & enabled;
		run_next.reverse = rev_cmd;
		run_next.ext_fault = fault;
		run_next.stop_cmd = (st_reg == RUN_ACTIVE) & (st_next != RUN_ACTIVE);
		dis_next = ~enabled;
		stm_next = stopping_method_select;
		// brake while stopped, release on run or jog
		dc_next = dc_reg;
		if (run_cmd | jog_cmd) dc_next = 1'b0;
		else if (f_dc[0] & motor_stopped & (st_reg != RUN_ACTIVE)) dc_next = 1'b1;
		else if (~f_dc[0]) dc_next = 1'b0;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= RUN_IDLE;
			hsb_reg <= 1'b0;
			dc_reg <= 1'b0;
			run_reg <= '0;
			dis_reg <= 1'b0;
			stm_reg <= '0;
		end else begin
			st_reg <= st_next;
			hsb_reg <= hsb_next;
			dc_reg <= dc_next;
			run_reg <= run_next;
			dis_reg <= dis_next;
			stm_reg <= stm_next;
		end
	end

	// pid, preset, offsets, search, ride-through
	pid_ctl_t pid_reg, pid_next;
	logic [3:0] pre_reg, pre_next;
	logic [`BIAS_W-1:0] off_reg, off_next;
	logic [2:0] ss_reg, ss_next;
	logic cc_reg, cc_next, keb_reg, keb_next;
	always_comb begin
		pid_next.int_reset = f_ir[0];
		pid_next.int_hold = f_ih[0] & ~f_ir[0];
		pid_next.sfs_cancel = f_sfs[0];
		pid_next.sign_inv = f_inv[0];
		pre_next = {f_p4[0], preset_sel_low};
		off_next = (f_o1[0] ? offset_freq1 : '0) + (f_o2[0] ? offset_freq2 : '0)
			+ (f_o3[0] ? offset_freq3 : '0);
		ss_next[0] = speed_search_at_start | f_s1[0] | f_s2[0];
		ss_next[1] = ~speed_search_method & f_s1[0];
		ss_next[2] = ~speed_search_method & f_s2[0];
		cc_next = f_s1[1] & f_s2[1];
		keb_next = (f_knc[1] & ~f_knc[0]) | f_kno[0];
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pid_reg <= '0;
			pre_reg <= '0;
			off_reg <= '0;
			ss_reg <= '0;
			cc_reg <= 1'b0;
			keb_reg <= 1'b0;
		end else begin
			pid_reg <= pid_next;
			pre_reg <= pre_next;
			off_reg <= off_next;
			ss_reg <= ss_next;
			cc_reg <= cc_next;
			keb_reg <= keb_next;
		end
	end

	// loopback: toggle tx, registered rx must match tx of one cycle before
	logic tx_reg, tx_next, lbok_reg, lbok_next, lba_reg, lba_next, exp_reg, exp_next;
	logic rx_reg, rx_next;
	always_comb begin
		lba_next = f_lb[0];
		tx_next = lba_next ? ~tx_reg : 1'b1;
		exp_next = tx_reg;
		rx_next = serial_rx;
		lbok_next = lba_reg ? (lbok_reg & (rx_reg == exp_reg)) : 1'b1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_reg <= 1'b1;
			exp_reg <= 1'b1;
			rx_reg <= 1'b1;
			lbok_reg <= 1'b1;
			lba_reg <= 1'b0;
		end else begin
			tx_reg <= tx_next;
			exp_reg <= exp_next;
			rx_reg <= rx_next;
			lbok_reg <= lbok_next;
			lba_reg <= lba_next;
		end
	end

	// bias stepping, save after steady period
	logic [`BIAS_W-1:0] bias_reg, bias_next, sav_reg, sav_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic sp_reg, sp_next;
	always_comb begin
		bias_next = bias_reg;
		if (f_up[0] & ~f_dn[0]) bias_next = bias_reg + bias_step;
		else if (f_dn[0] & ~f_up[0]) bias_next = bias_reg - bias_step;
		cnt_next = cnt_reg;
		sav_next = sav_reg;
		sp_next = 1'b0;
		if (bias_next != bias_reg) cnt_next = '0;
		else if (cnt_reg < CW'(SAVE_CYCLES)) begin
			cnt_next = cnt_reg + 1'b1;
			if (cnt_next == CW'(SAVE_CYCLES) && bias_save_enable) begin
				sav_next = bias_reg;
				sp_next = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			bias_reg <= '0;
			sav_reg <= '0;
			cnt_reg <= '0;
			sp_reg <= 1'b0;
		end else begin
			bias_reg <= bias_next;
			sav_reg <= sav_next;
			cnt_reg <= cnt_next;
			sp_reg <= sp_next;
		end
	end

	assign serial_tx = tx_reg;
	assign loopback_ok = lbok_reg;
	assign loopback_active = lba_reg;
	assign pid_ctl = pid_reg;
	assign run_ctl = run_reg;
	assign stop_method = stm_reg;
	assign preset_sel = pre_reg;
	assign offset_total = off_reg;
	assign dc_brake = dc_reg;
	assign search_enable = ss_reg[0];
	assign search_from_max = ss_reg[1];
	assign search_from_ref = ss_reg[2];
	assign config_conflict_error = cc_reg;
	assign kinetic_energy_ride_through = keb_reg;
	assign high_slip_braking = hsb_reg;
	assign drive_disabled_indication = dis_reg;
	assign bias_value = bias_reg;
	assign saved_bias_value = sav_reg;
	assign bias_saved_pulse = sp_reg;

	chk_reset_zero_hold: assert property (@(posedge clk) disable iff (rst)
		f_ir[0] |=> pid_ctl.int_reset && !pid_ctl.int_hold)
		else $error("integral reset not held");
	chk_hold_level: assert property (@(posedge clk) disable iff (rst)
		(f_ih[0] && !f_ir[0]) |=> pid_ctl.int_hold)
		else $error("integral hold missing");
	chk_fault_no_run: assert property (@(posedge clk) disable iff (rst)
		fault |=> run_ctl.ext_fault && !run_ctl.run)
		else $error("run during direction fault");
	chk_disabled_no_run: assert property (@(posedge clk) disable iff (rst)
		!enabled |=> !run_ctl.run && drive_disabled_indication)
		else $error("run while disabled");
	chk_run_cycle: assert property (@(posedge clk) disable iff (rst)
		(st_reg == RUN_WAIT_CYCLE && run_cmd) |=> !run_ctl.run)
		else $error("run without cycling");
	chk_enable_stop: assert property (@(posedge clk) disable iff (rst)
		(st_reg == RUN_ACTIVE && !enabled) |=> run_ctl.stop_cmd)
		else $error("no stop on enable loss");
	chk_hsb_latch: assert property (@(posedge clk) disable iff (rst)
		(high_slip_braking && !motor_stopped) |=> high_slip_braking)
		else $error("braking released early");
	chk_conflict_flag: assert property (@(posedge clk) disable iff (rst)
		(f_s1[1] && f_s2[1]) |=> config_conflict_error)
		else $error("search conflict not flagged");
	chk_dc_release: assert property (@(posedge clk) disable iff (rst)
		(run_cmd || jog_cmd) |=> !dc_brake)
		else $error("brake not released");
	chk_bias_save: assert property (@(posedge clk) disable iff (rst)
		bias_saved_pulse |-> saved_bias_value == bias_value && $stable(bias_value))
		else $error("bias save mismatch");
endmodule
`default_nettype wire

// ===== sim/terminal_contacts.sv
// external contacts on the input terminals and the send-to-receive wire tie
// assumes the bench changes closed and loop_break just after a rising edge
`default_nettype none
module terminal_contacts (
	input wire logic [6:0] closed,
	input wire logic loop_break,
	input wire logic serial_tx,
	output logic [6:0] term_in,
	output logic serial_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	assign term_in = closed;
	assign serial_rx = loop_break ? ~serial_tx : serial_tx;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the digital input function logic
// assumes the contacts model and a shortened bias save count of 20 cycles
`default_nettype none
`include "difl_map.svh"
module tb;
	import difl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] U = 8'hFF;
	logic clk, rst, brk, bse, jog, mst, ssa, ssm;
	logic [6:0] closed, term_in, inv;
	logic [55:0] ifs;
	logic [2:0] psl;
	logic [1:0] sms, stop_method;
	logic [15:0] of1, of2, of3, step, offset_total, bias_value, saved_bias_value;
	logic serial_tx, serial_rx, loopback_ok, loopback_active, dc_brake, search_enable;
	logic search_from_max, search_from_ref, config_conflict_error;
	logic kinetic_energy_ride_through, high_slip_braking, drive_disabled_indication;
	logic bias_saved_pulse;
	logic [3:0] preset_sel;
	pid_ctl_t pid_ctl;
	run_ctl_t run_ctl;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	terminal_contacts u_contacts (.closed(closed), .loop_break(brk),
		.serial_tx(serial_tx), .term_in(term_in), .serial_rx(serial_rx));
	digital_input_function_logic #(.N_IN(7), .SAVE_CYCLES(20)) u_dut (.clk(clk), .rst(rst),
		.term_in(term_in), .input_function_select(ifs), .term_invert(inv),
		.preset_sel_low(psl), .offset_freq1(of1), .offset_freq2(of2), .offset_freq3(of3),
		.bias_step(step), .bias_save_enable(bse), .jog_cmd(jog), .motor_stopped(mst),
		.speed_search_at_start(ssa), .speed_search_method(ssm),
		.stopping_method_select(sms), .serial_rx(serial_rx), .serial_tx(serial_tx),
		.loopback_ok(loopback_ok), .loopback_active(loopback_active), .pid_ctl(pid_ctl),
		.run_ctl(run_ctl), .stop_method(stop_method), .preset_sel(preset_sel),
		.offset_total(offset_total), .dc_brake(dc_brake), .search_enable(search_enable),
		.search_from_max(search_from_max), .search_from_ref(search_from_ref),
		.config_conflict_error(config_conflict_error),
		.kinetic_energy_ride_through(kinetic_energy_ride_through),
		.high_slip_braking(high_slip_braking),
		.drive_disabled_indication(drive_disabled_indication), .bias_value(bias_value),
		.saved_bias_value(saved_bias_value), .bias_saved_pulse(bias_saved_pulse));
	task automatic complete_run();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic setc(input logic [6:0] v);
		closed <= v;
		wt(4);
	endtask
	// reconfigure the terminal codes under reset, codes are static otherwise
	task automatic cfg(input logic [55:0] c);
		rst <= 1'b1;
		closed <= '0;
		ifs <= c;
		wt(2);
		rst <= 1'b0;
		wt(4);
	endtask
	task automatic t_pid();
		cfg({U, U, `FC_PRESET_BIT4, `FC_PID_SIGN_INV, `FC_PID_SFS_CANCEL,
			`FC_PID_INT_HOLD, `FC_PID_INT_RESET});
		psl <= 3'h5;
		setc(7'h01);
		chk("pid_reset", pid_ctl, 16'h0008);
		setc(7'h02);
		chk("pid_hold", pid_ctl, 16'h0004);
		setc(7'h04);
		chk("pid_sfs", pid_ctl, 16'h0002);
		setc(7'h08);
		chk("pid_sign", pid_ctl, 16'h0001);
		setc(7'h10);
		chk("preset_hi", preset_sel, 16'h000D);
		setc(7'h00);
		chk("preset_lo", preset_sel, 16'h0005);
	endtask
	// scheme one alone on this device
	task automatic t_run1();
		cfg({U, U, U, U, `FC_ENABLE, `FC_REV_RUN, `FC_FWD_RUN});
		setc(7'h05);
		chk("fwd", {run_ctl.run, run_ctl.reverse}, 16'h0002);
		setc(7'h06);
		chk("rev", {run_ctl.run, run_ctl.reverse}, 16'h0003);
		setc(7'h07);
		chk("both", {run_ctl.run, run_ctl.ext_fault}, 16'h0001);
		setc(7'h01);
		chk("dis_run", run_ctl.run, 16'h0000);
		chk("dis_ind", drive_disabled_indication, 16'h0001);
		setc(7'h05);
		chk("held_run", run_ctl.run, 16'h0000);
		chk("en_ind", drive_disabled_indication, 16'h0000);
		setc(7'h04);
		setc(7'h05);
		chk("cycled", run_ctl.run, 16'h0001);
		setc(7'h01);
		chk("en_drop", run_ctl.run, 16'h0000);
		chk("stop_m", stop_method, 16'h0002);
	endtask
	// scheme two alone on this device
	task automatic t_run2();
		cfg({U, U, U, U, U, `FC_DIR2, `FC_RUN2});
		setc(7'h01);
		chk("run2_f", {run_ctl.run, run_ctl.reverse}, 16'h0002);
		setc(7'h03);
		chk("run2_r", {run_ctl.run, run_ctl.reverse}, 16'h0003);
		setc(7'h02);
		chk("run2_off", run_ctl.run, 16'h0000);
	endtask
	task automatic t_misc();
		cfg({U, U, U, U, `FC_OFFSET3, `FC_OFFSET2, `FC_OFFSET1});
		setc(7'h01);
		chk("ofs1", offset_total, of1);
		setc(7'h06);
		chk("ofs23", offset_total, of2 + of3);
		setc(7'h07);
		chk("ofs123", offset_total, of1 + of2 + of3);
		cfg({U, U, U, U, U, U, `FC_DC_BRAKE});
		mst <= 1'b1;
		setc(7'h01);
		chk("dcb_on", dc_brake, 16'h0001);
		jog <= 1'b1;
		wt(4);
		chk("dcb_jog", dc_brake, 16'h0000);
		jog <= 1'b0;
		cfg({U, U, U, U, U, U, `FC_SEARCH1});
		setc(7'h01);
		chk("srch1", {search_enable, search_from_max, search_from_ref}, 16'h0006);
		chk("no_conf", config_conflict_error, 16'h0000);
		cfg({U, U, U, U, U, U, `FC_SEARCH2});
		setc(7'h01);
		chk("srch2", {search_enable, search_from_max, search_from_ref}, 16'h0005);
		ssm <= 1'b1;
		wt(4);
		chk("srch2_m", {search_enable, search_from_max, search_from_ref}, 16'h0004);
		ssm <= 1'b0;
		cfg({U, U, U, U, U, `FC_SEARCH2, `FC_SEARCH1});
		chk("conflict", config_conflict_error, 16'h0001);
	endtask
	task automatic t_keb();
		cfg({U, U, U, U, U, `FC_KEB_NO, `FC_KEB_NC});
		inv <= 7'h02;
		setc(7'h03);
		chk("keb_norm", kinetic_energy_ride_through, 16'h0000);
		setc(7'h02);
		chk("keb_nc", kinetic_energy_ride_through, 16'h0001);
		setc(7'h01);
		chk("keb_inv", kinetic_energy_ride_through, 16'h0001);
		inv <= '0;
		setc(7'h03);
		chk("keb_no", kinetic_energy_ride_through, 16'h0001);
	endtask
	task automatic t_loop_hsb();
		logic t;
		cfg({U, U, U, U, U, U, `FC_LOOPBACK});
		setc(7'h01);
		t = serial_tx;
		wt(1);
		chk("tx_tog", serial_tx, {15'h0000, ~t});
		chk("lb_act", loopback_active, 16'h0001);
		chk("lb_ok", loopback_ok, 16'h0001);
		brk <= 1'b1;
		wt(4);
		chk("lb_bad", loopback_ok, 16'h0000);
		brk <= 1'b0;
		cfg({U, U, U, U, U, U, `FC_HSB});
		mst <= 1'b0;
		setc(7'h01);
		chk("hsb_on", high_slip_braking, 16'h0001);
		setc(7'h00);
		chk("hsb_held", high_slip_braking, 16'h0001);
		mst <= 1'b1;
		wt(4);
		chk("hsb_clr", high_slip_braking, 16'h0000);
	endtask
	task automatic t_bias();
		logic [15:0] seen;
		cfg({U, U, U, U, U, `FC_BIAS_DOWN, `FC_BIAS_UP});
		setc(7'h01);
		closed <= 7'h00;
		wt(4);
		chk("bias_up", bias_value, 16'h0040);
		setc(7'h03);
		closed <= 7'h00;
		wt(4);
		chk("bias_both", bias_value, 16'h0040);
		closed <= 7'h02;
		wt(2);
		closed <= 7'h00;
		wt(4);
		chk("bias_dn", bias_value, 16'h0020);
		seen = 16'h0000;
		repeat (30) begin
			if (bias_saved_pulse === 1'b1) seen = seen + 16'h0001;
			wt(1);
		end
		chk("save_pulse", seen, 16'h0001);
		chk("bias_save", saved_bias_value, 16'h0020);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		rst = 1'b1;
		closed = '0;
		ifs = {7{U}};
		inv = '0;
		psl = '0;
		{of1, of2, of3, step} = {16'h0011, 16'h0120, 16'h1300, 16'h0010};
		{bse, jog, mst, ssa, ssm, brk} = '0;
		bse = 1'b1;
		sms = 2'h2;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		t_pid();
		t_run1();
		t_run2();
		t_misc();
		t_keb();
		t_loop_hsb();
		t_bias();
		complete_run();
	end
endmodule
`default_nettype wire
